// *** core/dem_top.v ***
// execution monitor top: ahb-lite slave, block counter, interrupts
//
// Functional notes
// - watchdog period is prescale interval multiplied by the start value
// - prescale code 0000 steps every 64 cycles, doubling up to code 1011
// - enable bit 0 gates block interrupt generation
// - block counter advances on each frame-start pulse while enable bit 0 is set, else held at zero
// - at programmed block length raise block interrupt and restart counter
// - current 24-bit pc readable: bits 23..16 high register, 15..0 low
// - clear control at 1 zeroes and freezes observed pc; at 0 updates
// - setting then releasing clear bit resets since-start peak registers
// - last-frame peak pair records highest pc during latest frame
// - clear control also zeroes the last-frame peak pair
// - since-start peak pair updates when a larger pc appears while clear is 0
// - watchdog counts down from start, reloads on restart, errors at zero
// - watchdog start value is 13 bits in low register bits
`timescale 1ns/1ps
`include "dem_regs.vh"
module dem_top #(
	parameter [`DEM_WD_DIV_W-1:0] WD_BASE_CYCLES = `DEM_WD_BASE_CYCLES
) (
	input wire CLK_IN,
	input wire RST_N_IN,
	input wire HSEL_IN,
	input wire [31:0] HADDR_IN,
	input wire [1:0] HTRANS_IN,
	input wire HWRITE_IN,
	input wire [2:0] HSIZE_IN,
	input wire [31:0] HWDATA_IN,
	input wire HREADY_IN,
	output reg [31:0] HRDATA_OUT,
	output reg HREADYOUT_OUT,
	output reg HRESP_OUT,
	input wire [`DEM_PC_W-1:0] PC_IN,
	input wire FRAME_START_IN,
	input wire PROG_RESTART_IN,
	output reg BLOCK_IRQ_OUT,
	output reg WATCHDOG_ERR_OUT,
	output reg IRQ_OUT
);
	// software registers
	reg [`DEM_WD_START_W-1:0] wd_start_ff;
	reg [`DEM_WD_STEP_W-1:0] wd_step_ff;
	reg blk_en_ff;
	reg [`DEM_BLK_LEN_W-1:0] blk_len_ff;
	reg pc_clear_ff;
	reg [`DEM_IRQ_W-1:0] irq_status_ff;
	reg [`DEM_IRQ_W-1:0] irq_mask_ff;

	// block counter
	reg [`DEM_BLK_LEN_W-1:0] blk_cnt_ff;
	reg [`DEM_BLK_LEN_W-1:0] nxt_blk_cnt;
	reg nxt_blk_irq;

	// bus pipeline
	reg wr_pend_ff;
	reg rd_pend_ff;
	reg [15:0] addr_idx_ff;
	wire accept;
	wire take_write;
	wire take_read;
	wire do_write;
	reg [31:0] nxt_rdata;

	// interrupt status next value
	reg [`DEM_IRQ_W-1:0] nxt_status;
	reg [`DEM_IRQ_W-1:0] irq_events;

	// monitor outputs
	wire wd_expire;
	wire [`DEM_PC_W-1:0] pc_value;
	wire [`DEM_PC_W-1:0] frame_peak;
	wire [`DEM_PC_W-1:0] alltime_peak;

	// word index of a byte address
	function [15:0] word_index;
		input [31:0] addr;
		begin
			word_index = addr[17:2];
		end
	endfunction

	// high half of a 24-bit value, zero above bit 7
	function [31:0] high_word;
		input [`DEM_PC_W-1:0] v;
		begin
			high_word = {24'h000000, v[`DEM_PC_HIGH_MSB:`DEM_PC_HIGH_LSB]};
		end
	endfunction

	// low half of a 24-bit value
	function [31:0] low_word;
		input [`DEM_PC_W-1:0] v;
		begin
			low_word = {16'h0000, v[`DEM_PC_LOW_MSB:0]};
		end
	endfunction

	// address phase
	assign accept = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
	assign take_write = accept & HWRITE_IN & (HSIZE_IN == `DEM_HSIZE_WORD);
	assign take_read = accept & ~HWRITE_IN;
	assign do_write = wr_pend_ff & HREADY_IN;

	// watchdog
	dem_watchdog #(
		.BASE_CYCLES(WD_BASE_CYCLES)
	) u_watchdog (
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.step_select_in(wd_step_ff),
		.start_value_in(wd_start_ff),
		.restart_in(PROG_RESTART_IN),
		.expire_out(wd_expire)
	);

	// program-counter monitor
	dem_pc_monitor u_pc_monitor (
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.clear_in(pc_clear_ff),
		.pc_in(PC_IN),
		.frame_start_in(FRAME_START_IN),
		.pc_value_out(pc_value),
		.frame_peak_out(frame_peak),
		.alltime_peak_out(alltime_peak)
	);

	// block counter next state
	always @* begin
		nxt_blk_cnt = blk_cnt_ff;
		nxt_blk_irq = 1'b0;
		if (!blk_en_ff) begin
			nxt_blk_cnt = 16'h0000;
		end else if (FRAME_START_IN) begin
			nxt_blk_cnt = blk_cnt_ff + 16'h0001;
			if (nxt_blk_cnt >= blk_len_ff) begin
				nxt_blk_cnt = 16'h0000;
				nxt_blk_irq = 1'b1;
			end
		end
	end

	// sticky status: a new event wins over a write-one clear
	always @* begin
		irq_events = `DEM_RST_IRQ;
		irq_events[`DEM_IRQ_BLOCK_BIT] = nxt_blk_irq;
		irq_events[`DEM_IRQ_WDOG_BIT] = wd_expire;
		nxt_status = irq_status_ff;
		if (do_write && (addr_idx_ff == `DEM_IDX_IRQ_STATUS)) begin
			nxt_status = irq_status_ff & ~HWDATA_IN[`DEM_IRQ_W-1:0];
		end
		nxt_status = nxt_status | irq_events;
	end

	// read data mux
	always @* begin
		nxt_rdata = 32'h00000000;
		case (addr_idx_ff)
			`DEM_IDX_WD_START: begin
				nxt_rdata = {19'h00000, wd_start_ff};
			end
			`DEM_IDX_WD_STEP: begin
				nxt_rdata = {28'h0000000, wd_step_ff};
			end
			`DEM_IDX_BLK_EN: begin
				nxt_rdata = {31'h00000000, blk_en_ff};
			end
			`DEM_IDX_BLK_LEN: begin
				nxt_rdata = {16'h0000, blk_len_ff};
			end
			`DEM_IDX_PC_HIGH: begin
				nxt_rdata = high_word(pc_value);
			end
			`DEM_IDX_PC_LOW: begin
				nxt_rdata = low_word(pc_value);
			end
			`DEM_IDX_PC_CLEAR: begin
				nxt_rdata = {31'h00000000, pc_clear_ff};
			end
			`DEM_IDX_FPEAK_HIGH: begin
				nxt_rdata = high_word(frame_peak);
			end
			`DEM_IDX_FPEAK_LOW: begin
				nxt_rdata = low_word(frame_peak);
			end
			`DEM_IDX_APEAK_HIGH: begin
				nxt_rdata = high_word(alltime_peak);
			end
			`DEM_IDX_APEAK_LOW: begin
				nxt_rdata = low_word(alltime_peak);
			end
			`DEM_IDX_IRQ_STATUS: begin
				nxt_rdata = {30'h00000000, irq_status_ff};
			end
			`DEM_IDX_IRQ_MASK: begin
				nxt_rdata = {30'h00000000, irq_mask_ff};
			end
			default: begin
				nxt_rdata = 32'h00000000;
			end
		endcase
	end

	// bus slave: writes finish with no wait, reads take one wait state
	// pending flags for the data phase
	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			wr_pend_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
		end else if (rd_pend_ff) begin
			rd_pend_ff <= 1'b0;
		end else begin
			wr_pend_ff <= take_write;
			rd_pend_ff <= take_read;
		end
	end

	// address phase capture; held through the read wait cycle
	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			addr_idx_ff <= 16'h0000;
		end else if (!rd_pend_ff && accept) begin
			addr_idx_ff <= word_index(HADDR_IN);
		end
	end

	// read data loads in the wait cycle and stands until the next read
	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			HRDATA_OUT <= 32'h00000000;
		end else if (rd_pend_ff) begin
			HRDATA_OUT <= nxt_rdata;
		end
	end

	// ready drops for one cycle after a read is taken
	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			HREADYOUT_OUT <= 1'b1;
		end else if (rd_pend_ff) begin
			HREADYOUT_OUT <= 1'b1;
		end else begin
			HREADYOUT_OUT <= ~take_read;
		end
	end

	// response is always okay
	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			HRESP_OUT <= 1'b0;
		end else begin
			HRESP_OUT <= 1'b0;
		end
	end

	// register writes; read-only and unmapped words are ignored
	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			wd_start_ff <= `DEM_RST_WD_START;
			wd_step_ff <= `DEM_RST_WD_STEP;
			blk_en_ff <= 1'b0;
			blk_len_ff <= `DEM_RST_BLK_LEN;
			pc_clear_ff <= 1'b0;
			irq_mask_ff <= `DEM_RST_IRQ;
		end else if (do_write) begin
			case (addr_idx_ff)
				`DEM_IDX_WD_START: begin
					wd_start_ff <= HWDATA_IN[`DEM_WD_START_W-1:0];
				end
				`DEM_IDX_WD_STEP: begin
					wd_step_ff <= HWDATA_IN[`DEM_WD_STEP_W-1:0];
				end
				`DEM_IDX_BLK_EN: begin
					blk_en_ff <= HWDATA_IN[`DEM_ENABLE_BIT];
				end
				`DEM_IDX_BLK_LEN: begin
					blk_len_ff <= HWDATA_IN[`DEM_BLK_LEN_W-1:0];
				end
				`DEM_IDX_PC_CLEAR: begin
					pc_clear_ff <= HWDATA_IN[`DEM_CLEAR_BIT];
				end
				`DEM_IDX_IRQ_MASK: begin
					irq_mask_ff <= HWDATA_IN[`DEM_IRQ_W-1:0];
				end
				default: begin
					pc_clear_ff <= pc_clear_ff;
				end
			endcase
		end
	end

	// block counter
	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			blk_cnt_ff <= 16'h0000;
		end else begin
			blk_cnt_ff <= nxt_blk_cnt;
		end
	end

	// block interrupt pulse
	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			BLOCK_IRQ_OUT <= 1'b0;
		end else begin
			BLOCK_IRQ_OUT <= nxt_blk_irq;
		end
	end

	// watchdog error pulse towards the panic manager
	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			WATCHDOG_ERR_OUT <= 1'b0;
		end else begin
			WATCHDOG_ERR_OUT <= wd_expire;
		end
	end

	// sticky status bits
	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			irq_status_ff <= `DEM_RST_IRQ;
		end else begin
			irq_status_ff <= nxt_status;
		end
	end

	// level interrupt, same edge as the status update
	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			IRQ_OUT <= 1'b0;
		end else begin
			IRQ_OUT <= |(nxt_status & irq_mask_ff);
		end
	end
endmodule

// *** core/dem_regs.vh ***
// register indices, field positions, reset values and timing for the execution monitor
`ifndef DEM_REGS_VH
`define DEM_REGS_VH

// register indices; the byte address is four times the index
`define DEM_IDX_WD_START 16'hf443
`define DEM_IDX_WD_STEP 16'hf444
`define DEM_IDX_BLK_EN 16'hf450
`define DEM_IDX_BLK_LEN 16'hf451
`define DEM_IDX_PC_HIGH 16'hf460
`define DEM_IDX_PC_LOW 16'hf461
`define DEM_IDX_PC_CLEAR 16'hf462
`define DEM_IDX_FPEAK_HIGH 16'hf463
`define DEM_IDX_FPEAK_LOW 16'hf464
`define DEM_IDX_APEAK_HIGH 16'hf465
`define DEM_IDX_APEAK_LOW 16'hf466
`define DEM_IDX_IRQ_STATUS 16'hf470
`define DEM_IDX_IRQ_MASK 16'hf471

// field widths and positions
`define DEM_WD_START_W 13
`define DEM_WD_STEP_W 4
`define DEM_BLK_LEN_W 16
`define DEM_PC_W 24
`define DEM_PC_HIGH_MSB 23
`define DEM_PC_HIGH_LSB 16
`define DEM_PC_LOW_MSB 15
`define DEM_ENABLE_BIT 0
`define DEM_CLEAR_BIT 0
`define DEM_IRQ_W 2
`define DEM_IRQ_BLOCK_BIT 0
`define DEM_IRQ_WDOG_BIT 1

// reset values
`define DEM_RST_WD_START 13'h0000
`define DEM_RST_WD_STEP 4'h0
`define DEM_RST_BLK_LEN 16'h0000
`define DEM_RST_PC 24'h000000
`define DEM_RST_IRQ 2'h0

// watchdog step timing: base interval in cycles for code 0000, largest code 1011
`define DEM_WD_BASE_CYCLES 18'h00040
`define DEM_WD_DIV_W 18
`define DEM_WD_CODE_MAX 4'hb

// ahb encodings
`define DEM_HSIZE_WORD 3'h2
`endif

// *** core/dem_watchdog.v ***
// watchdog prescaler and countdown
`timescale 1ns/1ps
`include "dem_regs.vh"
module dem_watchdog #(
	parameter [`DEM_WD_DIV_W-1:0] BASE_CYCLES = `DEM_WD_BASE_CYCLES
) (
	input wire clk_in,
	input wire rst_n_in,
	input wire [`DEM_WD_STEP_W-1:0] step_select_in,
	input wire [`DEM_WD_START_W-1:0] start_value_in,
	input wire restart_in,
	output reg expire_out
);
	reg [`DEM_WD_DIV_W-1:0] div_ff;
	reg [`DEM_WD_START_W-1:0] count_ff;
	reg armed_ff;
	wire step;

	// reserved codes fall back to the largest interval
	function [`DEM_WD_DIV_W-1:0] step_interval;
		input [`DEM_WD_STEP_W-1:0] code;
		begin
			if (code > `DEM_WD_CODE_MAX) begin
				step_interval = BASE_CYCLES << `DEM_WD_CODE_MAX;
			end else begin
				step_interval = BASE_CYCLES << code;
			end
		end
	endfunction

	// one step per interval, so the total is interval times start value
	assign step = (div_ff == (step_interval(step_select_in) - 18'h00001));

	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			div_ff <= 18'h00000;
			count_ff <= `DEM_RST_WD_START;
			armed_ff <= 1'b0;
			expire_out <= 1'b0;
		end else begin
			expire_out <= 1'b0;
			if (restart_in) begin
				div_ff <= 18'h00000;
				count_ff <= start_value_in;
				armed_ff <= 1'b1;
			end else begin
				div_ff <= step ? 18'h00000 : div_ff + 18'h00001;
				if (step && armed_ff) begin
					if (count_ff <= 13'h0001) begin
						count_ff <= 13'h0000;
						armed_ff <= 1'b0;
						expire_out <= 1'b1;
					end else begin
						count_ff <= count_ff - 13'h0001;
					end
				end
			end
		end
	end
endmodule

// *** core/dem_pc_monitor.v ***
// program-counter snapshot and peak trackers
`timescale 1ns/1ps
`include "dem_regs.vh"
module dem_pc_monitor (
	input wire clk_in,
	input wire rst_n_in,
	input wire clear_in,
	input wire [`DEM_PC_W-1:0] pc_in,
	input wire frame_start_in,
	output reg [`DEM_PC_W-1:0] pc_value_out,
	output reg [`DEM_PC_W-1:0] frame_peak_out,
	output reg [`DEM_PC_W-1:0] alltime_peak_out
);
	reg [`DEM_PC_W-1:0] run_max_ff;
	reg clear_d_ff;
	wire release_clear;

	function [`DEM_PC_W-1:0] max24;
		input [`DEM_PC_W-1:0] a;
		input [`DEM_PC_W-1:0] b;
		begin
			max24 = (a > b) ? a : b;
		end
	endfunction

	assign release_clear = clear_d_ff & ~clear_in;

	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			pc_value_out <= `DEM_RST_PC;
			frame_peak_out <= `DEM_RST_PC;
			alltime_peak_out <= `DEM_RST_PC;
			run_max_ff <= `DEM_RST_PC;
			clear_d_ff <= 1'b0;
		end else begin
			clear_d_ff <= clear_in;
			if (clear_in) begin
				pc_value_out <= `DEM_RST_PC;
				frame_peak_out <= `DEM_RST_PC;
				run_max_ff <= `DEM_RST_PC;
			end else begin
				pc_value_out <= pc_in;
				if (frame_start_in) begin
					frame_peak_out <= run_max_ff;
					run_max_ff <= pc_in;
				end else begin
					run_max_ff <= max24(run_max_ff, pc_in);
				end
			end
			if (release_clear) begin
				alltime_peak_out <= `DEM_RST_PC;
			end else if (!clear_in) begin
				alltime_peak_out <= max24(alltime_peak_out, pc_in);
			end
		end
	end
endmodule

// *** test/dem_top_asserts.sv ***
// port assertions for the execution monitor top
`timescale 1ns/1ps
module dem_top_chk (
	input wire CLK_IN,
	input wire RST_N_IN,
	input wire HSEL_IN,
	input wire [1:0] HTRANS_IN,
	input wire HWRITE_IN,
	input wire HREADY_IN,
	input wire [31:0] HRDATA_OUT,
	input wire HREADYOUT_OUT,
	input wire HRESP_OUT,
	input wire FRAME_START_IN,
	input wire BLOCK_IRQ_OUT,
	input wire WATCHDOG_ERR_OUT,
	input wire IRQ_OUT
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	wire rd_go = HSEL_IN && HTRANS_IN[1] && HREADY_IN && !HWRITE_IN;
	wire wr_go = HSEL_IN && HTRANS_IN[1] && HREADY_IN && HWRITE_IN;
	property p_ok;
		HRESP_OUT == 1'b0;
	endproperty
	a_ok: assert property (p_ok) else $error("response not okay");
	property p_rd_wait;
		rd_go |=> !HREADYOUT_OUT ##1 HREADYOUT_OUT;
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
	property p_wr_fast;
		wr_go |=> HREADYOUT_OUT;
	endproperty
	a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
	property p_rd_hold;
		$changed(HRDATA_OUT) |-> $rose(HREADYOUT_OUT);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_blk_cause;
		BLOCK_IRQ_OUT |-> $past(FRAME_START_IN) || $past(FRAME_START_IN, 2);
	endproperty
	a_blk_cause: assert property (p_blk_cause) else $error("block irq without frame");
	property p_wd_pulse;
		WATCHDOG_ERR_OUT |=> !WATCHDOG_ERR_OUT;
	endproperty
	a_wd_pulse: assert property (p_wd_pulse) else $error("watchdog error held");
	property p_rst;
		$rose(RST_N_IN) |-> !IRQ_OUT && !BLOCK_IRQ_OUT && !WATCHDOG_ERR_OUT
			&& HREADYOUT_OUT && HRDATA_OUT == 32'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not idle after reset");
	property p_irq_rise;
		$rose(IRQ_OUT) |-> BLOCK_IRQ_OUT || WATCHDOG_ERR_OUT || $past(wr_go, 2)
			|| $past(wr_go, 3);
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
endmodule

bind dem_top dem_top_chk chk_u (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .HSEL_IN(HSEL_IN),
	.HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HREADY_IN(HREADY_IN),
	.HRDATA_OUT(HRDATA_OUT), .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT),
	.FRAME_START_IN(FRAME_START_IN), .BLOCK_IRQ_OUT(BLOCK_IRQ_OUT),
	.WATCHDOG_ERR_OUT(WATCHDOG_ERR_OUT), .IRQ_OUT(IRQ_OUT));

// *** test/dem_top_tb.sv ***
// self-checking testbench for the execution monitor top
`timescale 1ns/1ps
`include "dem_regs.vh"
module dem_top_tb;
	logic clk = 0, rst_n = 0, hsel = 0, hwr = 0, fs = 0, rs = 0;
	logic [1:0] htr = 0;
	logic [2:0] hsz = 0;
	logic [31:0] ha = 0, hwd = 0;
	logic [23:0] pc = 0;
	wire [31:0] hrd;
	wire hrdy, blk, wd, irq;
	int num_errors = 0, checks_done = 0, nblk = 0;
	dem_top #(.WD_BASE_CYCLES(18'h1)) dut_u (.CLK_IN(clk), .RST_N_IN(rst_n), .HSEL_IN(hsel),
		.HADDR_IN(ha), .HTRANS_IN(htr), .HWRITE_IN(hwr), .HSIZE_IN(hsz), .HWDATA_IN(hwd),
		.HREADY_IN(hrdy), .HRDATA_OUT(hrd), .HREADYOUT_OUT(hrdy), .HRESP_OUT(), .PC_IN(pc),
		.FRAME_START_IN(fs), .PROG_RESTART_IN(rs), .BLOCK_IRQ_OUT(blk),
		.WATCHDOG_ERR_OUT(wd), .IRQ_OUT(irq));
	initial forever #2 clk = ~clk;
	always @(posedge clk) if (blk === 1'b1) nblk++;
	task check(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR %0t: got %h want %h", $time, s, e);
		end
	endtask
	task close_out;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task bus(input logic w, input logic [15:0] i, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1;
		htr <= 2'h2;
		hwr <= w;
		hsz <= `DEM_HSIZE_WORD;
		ha <= {14'h0, i, 2'h0};
		do @(posedge clk); while (hrdy !== 1'b1);
		htr <= 2'h0;
		hwd <= d;
		do @(posedge clk); while (hrdy !== 1'b1);
		r = hrd;
	endtask
	task wr(input logic [15:0] i, input logic [31:0] d);
		logic [31:0] x;
		bus(1, i, d, x);
	endtask
	task rdc(input logic [15:0] i, input logic [31:0] e);
		logic [31:0] x;
		bus(0, i, 0, x);
		check(x, e);
	endtask
	task frame;
		fs <= 1;
		@(posedge clk);
		fs <= 0;
		repeat (3) @(posedge clk);
	endtask
	task t_regs;
		logic [15:0] ids [0:9];
		logic [31:0] msk [0:9];
		ids = '{`DEM_IDX_WD_START, `DEM_IDX_WD_STEP, `DEM_IDX_BLK_EN, `DEM_IDX_BLK_LEN,
			`DEM_IDX_PC_CLEAR, `DEM_IDX_IRQ_MASK, `DEM_IDX_PC_HIGH, `DEM_IDX_PC_LOW,
			`DEM_IDX_APEAK_LOW, 16'hf400};
		msk = '{32'h1fff, 32'hf, 32'h1, 32'hffff, 32'h1, 32'h3, 0, 0, 0, 0};
		for (int k = 0; k < 10; k++) begin
			rdc(ids[k], 32'h0);
			wr(ids[k], 32'hffffffff);
			rdc(ids[k], msk[k]);
			wr(ids[k], 32'h0);
		end
	endtask
	task t_pc;
		pc <= 24'h000100;
		frame;
		pc <= 24'hab1234;
		rdc(`DEM_IDX_PC_HIGH, 32'hab);
		rdc(`DEM_IDX_PC_LOW, 32'h1234);
		pc <= 24'h000050;
		frame;
		rdc(`DEM_IDX_FPEAK_HIGH, 32'hab);
		rdc(`DEM_IDX_APEAK_LOW, 32'h1234);
		pc <= 24'h000200;
		frame;
		rdc(`DEM_IDX_FPEAK_LOW, 32'h50);
		rdc(`DEM_IDX_APEAK_HIGH, 32'hab);
		wr(`DEM_IDX_PC_CLEAR, 32'h1);
		rdc(`DEM_IDX_PC_LOW, 32'h0);
		rdc(`DEM_IDX_FPEAK_LOW, 32'h0);
		pc <= 24'h0;
		wr(`DEM_IDX_PC_CLEAR, 32'h0);
		rdc(`DEM_IDX_APEAK_HIGH, 32'h0);
		pc <= 24'h000321;
		rdc(`DEM_IDX_PC_LOW, 32'h321);
	endtask
	task t_blk;
		int n;
		wr(`DEM_IDX_BLK_LEN, 32'h3);
		n = nblk;
		repeat (6) frame;
		check(nblk - n, 0);
		wr(`DEM_IDX_BLK_EN, 32'h1);
		n = nblk;
		repeat (6) frame;
		check(nblk - n, 2);
		rdc(`DEM_IDX_IRQ_STATUS, 32'h1);
		check({31'h0, irq}, 0);
		wr(`DEM_IDX_IRQ_MASK, 32'h1);
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 1);
		wr(`DEM_IDX_IRQ_STATUS, 32'h1);
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 0);
		wr(`DEM_IDX_BLK_EN, 32'h0);
	endtask
	task wdrun(input logic [3:0] c, input logic [12:0] s, input int e);
		int k;
		wr(`DEM_IDX_WD_STEP, {28'h0, c});
		wr(`DEM_IDX_WD_START, {19'h0, s});
		rs <= 1;
		@(posedge clk);
		rs <= 0;
		k = 0;
		while (wd !== 1'b1 && k < 9000) begin
			@(posedge clk);
			k++;
		end
		check({31'h0, k >= e && k <= e + 4}, 1);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		t_regs;
		t_pc;
		t_blk;
		wdrun(4'h0, 13'h5, 5);
		wdrun(4'h2, 13'h4, 16);
		wdrun(4'hf, 13'h2, 4096);
		rdc(`DEM_IDX_IRQ_STATUS, 32'h2);
		close_out;
	end
	initial begin
		#200000;
		num_errors++;
		close_out;
	end
endmodule
